/* hw/pmc_top.sv */
// power mode sequencer, clock gating, retention, io latch and reset cause
// assumes synchronous inputs, one clock, a plain register port
`default_nettype none
module pmc_top (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // events
    input wire logic irq_any,
    input wire logic rtc_evt,
    input wire logic sensor_evt,
    input wire logic reset_pin_n,
    input wire logic por_det,
    input wire logic supply_low,
    input wire logic slow_xtal_fitted,
    input wire logic [pmc_pkg::NUM_IO-1:0] wake_pin_sel,
    // io
    input wire logic [pmc_pkg::NUM_IO-1:0] io_in,
    input wire logic [pmc_pkg::NUM_IO-1:0] io_core_out,
    output logic [pmc_pkg::NUM_IO-1:0] io_out,
    output logic io_latched,
    // clocks and power
    output logic cpu_clk_en,
    output logic mem_clk_en,
    output logic periph_clk_en,
    output logic radio_clk_en,
    output logic fast_crystal_osc_en,
    output logic fast_crystal_dbl_en,
    output logic fast_internal_osc_en,
    output logic slow_crystal_osc_en,
    output logic slow_internal_osc_en,
    output logic slow_clk_out_en,
    output logic always_on_domain_pwr,
    output logic sensor_pwr,
    output logic [pmc_pkg::NUM_SRAM-1:0] sram_pwr,
    output logic cache_as_ram,
    output logic brownout_detector_en,
    output logic por_det_en,
    output logic sys_reset_n,
    output logic bod_lock
);
    import pmc_pkg::*;

    pmc_mode_t mode_reg, mode_next, from_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [3:0] ret_reg;
    logic [1:0] clk_reg;
    logic cache_off_reg, sc_wake_reg, dip_reg, lock_reg;
    logic [3:0] cause_reg;
    logic [NUM_IO-1:0] io_prev_reg;
    logic [7:0] bod_cnt_reg;
    logic wake_pin_evt, cmd_wr, standby_wake, bod_trip;

    assign cmd_wr = wr && addr == ADDR_CTRL;
    // edge seen on any selected wake pin
    assign wake_pin_evt = |((io_in ^ io_prev_reg) & wake_pin_sel);
    // sensor only counts when its wake is enabled
    assign standby_wake = wake_pin_evt || rtc_evt || (sensor_evt && sc_wake_reg);
    assign bod_trip = supply_low && brownout_detector_en;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            io_prev_reg <= '0;
        end else if (ce) begin
            io_prev_reg <= io_in;
        end
    end

    // mode sequencer
    always_comb begin
        mode_next = mode_reg;
        if (!reset_pin_n) begin
            mode_next = PMC_RESET_HOLD;
        end else begin
            case (mode_reg)
                PMC_ACTIVE: begin
                    if (cmd_wr && wdata[CTRL_CMD_LSB +: 2] == CMD_IDLE) begin
                        mode_next = PMC_IDLE;
                    end else if (cmd_wr && wdata[CTRL_CMD_LSB +: 2] == CMD_STANDBY) begin
                        mode_next = PMC_STANDBY;
                    end else if (cmd_wr && wdata[CTRL_CMD_LSB +: 2] == CMD_SHUTDOWN) begin
                        mode_next = PMC_SHUTDOWN;
                    end
                end
                PMC_IDLE: if (irq_any) mode_next = PMC_WAKING;
                PMC_STANDBY: if (standby_wake) mode_next = PMC_WAKING;
                PMC_SHUTDOWN: if (wake_pin_evt) mode_next = PMC_WAKING;
                PMC_RESET_HOLD: mode_next = PMC_WAKING;
                PMC_WAKING: if (cnt_reg == '0 && !lock_reg) mode_next = PMC_ACTIVE;
                default: mode_next = PMC_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= PMC_WAKING;
            from_reg <= PMC_SHUTDOWN;
        end else if (ce) begin
            mode_reg <= mode_next;
            if (mode_next == PMC_WAKING && mode_reg != PMC_WAKING) begin
                from_reg <= mode_reg;
            end
        end
    end

    // wake delay counter, loaded per mode left
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= CNT_W'(WAKE_SHDN_CYC - 1);
        end else if (ce) begin
            if (mode_next == PMC_WAKING && mode_reg != PMC_WAKING) begin
                case (mode_reg)
                    PMC_IDLE: cnt_reg <= CNT_W'(WAKE_IDLE_CYC - 1);
                    PMC_STANDBY: cnt_reg <= CNT_W'(WAKE_STBY_CYC - 1);
                    default: cnt_reg <= CNT_W'(WAKE_SHDN_CYC - 1);
                endcase
            end else if (mode_reg == PMC_WAKING && cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // software registers; lost across shutdown and reset hold
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ret_reg <= RET_RESET;
            clk_reg <= '0;
            cache_off_reg <= 1'b0;
            sc_wake_reg <= 1'b0;
        end else if (ce) begin
            if (mode_reg == PMC_SHUTDOWN || mode_reg == PMC_RESET_HOLD) begin
                ret_reg <= RET_RESET;
                clk_reg <= '0;
                cache_off_reg <= 1'b0;
                sc_wake_reg <= 1'b0;
            end else if (wr && addr == ADDR_RET) begin
                ret_reg <= wdata[NUM_SRAM-1:0];
            end else if (wr && addr == ADDR_CLK) begin
                clk_reg <= wdata[1:0];
            end else if (cmd_wr) begin
                cache_off_reg <= wdata[CTRL_CACHE_OFF];
                sc_wake_reg <= wdata[CTRL_SC_WAKE_EN];
            end
        end
    end

    // reset cause; the event wins over a software clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cause_reg <= RST_POR;
        end else if (ce) begin
            if (por_det) begin
                cause_reg <= RST_POR;
            end else if (mode_reg == PMC_RESET_HOLD) begin
                cause_reg <= RST_PIN;
            end else if (mode_reg == PMC_SHUTDOWN && wake_pin_evt) begin
                cause_reg <= RST_WAKEPIN;
            end else if (bod_trip) begin
                cause_reg <= cause_reg | RST_BOD;
            end else if (wr && addr == ADDR_RST) begin
                cause_reg <= cause_reg & ~wdata[3:0];
            end
        end
    end

    // brownout duty cycle in standby and lock on wake
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bod_cnt_reg <= '0;
            dip_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else if (ce) begin
            // wraps at the period so the check pulse repeats in long standby
            if (mode_reg == PMC_STANDBY && bod_cnt_reg != 8'(BOD_PERIOD_CYC - 1)) begin
                bod_cnt_reg <= bod_cnt_reg + 1'b1;
            end else begin
                bod_cnt_reg <= '0;
            end
            if (mode_reg == PMC_STANDBY && supply_low) begin
                dip_reg <= 1'b1;
            end else if (mode_reg == PMC_ACTIVE) begin
                dip_reg <= 1'b0;
            end
            if (por_det || mode_reg == PMC_RESET_HOLD) begin
                lock_reg <= 1'b0;
            end else if (mode_reg == PMC_STANDBY && mode_next == PMC_WAKING && dip_reg) begin
                lock_reg <= 1'b1;
            end
        end
    end

    // io latch: hold last driven value in standby and shutdown
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            io_out <= '0;
            io_latched <= 1'b0;
        end else if (ce) begin
            io_latched <= mode_next == PMC_STANDBY || mode_next == PMC_SHUTDOWN;
            if (!(mode_reg == PMC_STANDBY || mode_reg == PMC_SHUTDOWN)) begin
                io_out <= clk_reg[CLK_LF_OUT] ? {io_core_out[NUM_IO-1:1], slow_clk_out_en}
                                              : io_core_out;
            end
        end
    end

    // clock gating and power outputs per mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_clk_en <= 1'b0;
            mem_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            radio_clk_en <= 1'b0;
            fast_crystal_osc_en <= 1'b0;
            fast_crystal_dbl_en <= 1'b0;
            fast_internal_osc_en <= 1'b0;
            slow_crystal_osc_en <= 1'b0;
            slow_internal_osc_en <= 1'b0;
            slow_clk_out_en <= 1'b0;
            always_on_domain_pwr <= 1'b0;
            sensor_pwr <= 1'b0;
            sram_pwr <= '0;
            cache_as_ram <= 1'b0;
            brownout_detector_en <= 1'b0;
            por_det_en <= 1'b1;
            sys_reset_n <= 1'b0;
            bod_lock <= 1'b0;
        end else if (ce) begin
            cpu_clk_en <= mode_next == PMC_ACTIVE;
            mem_clk_en <= mode_next == PMC_ACTIVE;
            periph_clk_en <= mode_next == PMC_ACTIVE || mode_next == PMC_IDLE;
            radio_clk_en <= mode_next == PMC_ACTIVE || mode_next == PMC_IDLE;
            // fast clock only outside standby/shutdown/hold
            fast_crystal_osc_en <= (mode_next == PMC_ACTIVE || mode_next == PMC_IDLE
                                    || mode_next == PMC_WAKING);
            fast_crystal_dbl_en <= (mode_next == PMC_ACTIVE || mode_next == PMC_IDLE
                                    || mode_next == PMC_WAKING);
            fast_internal_osc_en <= clk_reg[CLK_HF_INT] && (mode_next == PMC_ACTIVE
                                    || mode_next == PMC_IDLE);
            slow_crystal_osc_en <= slow_xtal_fitted && mode_next != PMC_SHUTDOWN
                                   && mode_next != PMC_RESET_HOLD;
            slow_internal_osc_en <= !slow_xtal_fitted && mode_next != PMC_SHUTDOWN
                                    && mode_next != PMC_RESET_HOLD;
            slow_clk_out_en <= clk_reg[CLK_LF_OUT] && mode_next != PMC_SHUTDOWN;
            always_on_domain_pwr <= mode_next != PMC_SHUTDOWN
                                    && mode_next != PMC_RESET_HOLD;
            sensor_pwr <= mode_next != PMC_SHUTDOWN && mode_next != PMC_RESET_HOLD;
            for (int i = 0; i < NUM_SRAM; i++) begin
                if (mode_next == PMC_SHUTDOWN || mode_next == PMC_RESET_HOLD) begin
                    sram_pwr[i] <= 1'b0;
                end else if (mode_next == PMC_STANDBY) begin
                    sram_pwr[i] <= ret_reg[i];
                end else begin
                    sram_pwr[i] <= 1'b1;
                end
            end
            cache_as_ram <= cache_off_reg;
            brownout_detector_en <= (mode_next == PMC_ACTIVE || mode_next == PMC_IDLE
                                     || mode_next == PMC_WAKING)
                                    || (mode_next == PMC_STANDBY
                                        && bod_cnt_reg == 8'(BOD_PERIOD_CYC - 1));
            por_det_en <= 1'b1;
            // standby and idle exits resume; others restart the cpu
            sys_reset_n <= !(mode_next == PMC_SHUTDOWN || mode_next == PMC_RESET_HOLD
                             || (mode_next == PMC_WAKING && from_reg != PMC_IDLE
                                 && from_reg != PMC_STANDBY));
            bod_lock <= lock_reg;
        end
    end

    // read port
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= '0;
            if (rd) begin
                case (addr)
                    ADDR_CTRL: rdata <= {28'h0, sc_wake_reg, cache_off_reg, 2'h0};
                    ADDR_RET: rdata <= {28'h0, ret_reg};
                    ADDR_CLK: rdata <= {30'h0, clk_reg};
                    ADDR_STAT: rdata <= {27'h0, lock_reg, 1'b0, mode_reg};
                    ADDR_RST: rdata <= {28'h0, cause_reg};
                    default: rdata <= '0;
                endcase
            end
        end
    end

    chk_idle_gates_cpu: assert property (@(posedge clk) disable iff (!arst_n)
        ce && mode_reg == PMC_IDLE && mode_next == PMC_IDLE |=> !cpu_clk_en && periph_clk_en)
        else $error("cpu clocked in idle");
    chk_standby_wake_src: assert property (@(posedge clk) disable iff (!arst_n)
        ce && mode_reg == PMC_STANDBY && reset_pin_n && !standby_wake |=> mode_reg == PMC_STANDBY)
        else $error("standby left without wake");
    chk_idle_wake_time: assert property (@(posedge clk) disable iff (!arst_n || !reset_pin_n)
        $rose(mode_reg == PMC_WAKING) && from_reg == PMC_IDLE && ce
        |-> ##278 mode_reg == PMC_WAKING ##[1:22] mode_reg != PMC_WAKING)
        else $error("idle wake time wrong");
    chk_shdn_no_fast: assert property (@(posedge clk) disable iff (!arst_n)
        mode_reg == PMC_SHUTDOWN && $past(mode_reg) == PMC_SHUTDOWN
        |-> !fast_crystal_osc_en && !always_on_domain_pwr)
        else $error("power on in shutdown");
    chk_io_held: assert property (@(posedge clk) disable iff (!arst_n)
        mode_reg == PMC_STANDBY && $past(mode_reg) == PMC_STANDBY |-> $stable(io_out))
        else $error("io moved in standby");
    chk_cause_pin: assert property (@(posedge clk) disable iff (!arst_n)
        ce && mode_reg == PMC_RESET_HOLD && !por_det |=> cause_reg == RST_PIN)
        else $error("reset pin cause lost");
    chk_sram_ret: assert property (@(posedge clk) disable iff (!arst_n)
        ce && mode_next == PMC_STANDBY |=> sram_pwr == $past(ret_reg))
        else $error("retention mismatch");
    chk_por_always: assert property (@(posedge clk) disable iff (!arst_n)
        por_det_en) else $error("por detect off");
endmodule
`default_nettype wire

/* common/pmc_pkg.sv */
// power mode control package: modes, register map, fields, timing counts
// assumes a 20 MHz system clock
`default_nettype none
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_ACTIVE, PMC_IDLE, PMC_STANDBY, PMC_SHUTDOWN, PMC_RESET_HOLD, PMC_WAKING
    } pmc_mode_t;
    localparam int CLK_HZ = 20000000;
    localparam int WAKE_IDLE_NS = 14000;
    localparam int WAKE_STBY_NS = 151000;
    localparam int WAKE_SHDN_NS = 1015000;
    localparam int CLK_NS = 1000000000 / CLK_HZ;
    localparam int WAKE_IDLE_CYC = WAKE_IDLE_NS / CLK_NS;
    localparam int WAKE_STBY_CYC = WAKE_STBY_NS / CLK_NS;
    localparam int WAKE_SHDN_CYC = WAKE_SHDN_NS / CLK_NS;
    localparam int BOD_PERIOD_CYC = 64;
    localparam int CNT_W = 16;
    localparam int NUM_SRAM = 4;
    localparam int NUM_IO = 16;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RET = 4'h1;
    localparam logic [3:0] ADDR_CLK = 4'h2;
    localparam logic [3:0] ADDR_WAKE = 4'h3;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_RST = 4'h5;
    localparam int CTRL_CMD_LSB = 0;
    localparam logic [1:0] CMD_IDLE = 2'h1;
    localparam logic [1:0] CMD_STANDBY = 2'h2;
    localparam logic [1:0] CMD_SHUTDOWN = 2'h3;
    localparam int CTRL_CACHE_OFF = 2;
    localparam int CTRL_SC_WAKE_EN = 3;
    localparam int CLK_HF_INT = 0;
    localparam int CLK_LF_OUT = 1;
    localparam logic [3:0] RET_RESET = 4'hf;
    localparam logic [3:0] RST_POR = 4'h1;
    localparam logic [3:0] RST_PIN = 4'h2;
    localparam logic [3:0] RST_WAKEPIN = 4'h4;
    localparam logic [3:0] RST_BOD = 4'h8;
endpackage
`default_nettype wire

/* verif/pmc_wake_partner.sv */
// wake source and reset pin model facing the power mode block
// assumes the bench pulses go for one cycle with kind and lag held
`default_nettype none
module pmc_wake_partner (
    // bench command
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [7:0] lag,
    input wire logic hold_pin,
    input wire logic [3:0] pin_idx,
    // event lines
    output logic irq_any,
    output logic rtc_evt,
    output logic sensor_evt,
    output logic reset_pin_n,
    output logic [15:0] io_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        irq_any = 1'b0;
        rtc_evt = 1'b0;
        sensor_evt = 1'b0;
        io_in = 16'h5a3c;
    end
    // plain level, low for as long as the bench holds it
    assign reset_pin_n = !hold_pin;
    // events arrive late by lag cycles, one cycle long: the shortest the block must catch
    always @(posedge clk) begin
        if (go) begin
            repeat (lag) @(posedge clk);
            case (kind)
                2'h0: irq_any <= 1'b1;
                2'h1: rtc_evt <= 1'b1;
                2'h2: sensor_evt <= 1'b1;
                default: io_in[pin_idx] <= ~io_in[pin_idx];
            endcase
            @(posedge clk);
            irq_any <= 1'b0;
            rtc_evt <= 1'b0;
            sensor_evt <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* verif/tb_power_mode_control.sv */
// self-checking bench for the power mode block with a wake source model
// assumes the register map and wake counts of the package
`default_nettype none
module tb_power_mode_control;
    timeunit 1ns;
    timeprecision 1ns;
    import pmc_pkg::*;
    logic clk, arst_n, wr, rd, go, hold_pin, supply_low, por_det, slow_xtal_fitted;
    logic irq_any, rtc_evt, sensor_evt, reset_pin_n, io_latched, cpu_clk_en, mem_clk_en;
    logic periph_clk_en, radio_clk_en, fast_crystal_osc_en, fast_crystal_dbl_en;
    logic fast_internal_osc_en, slow_crystal_osc_en, slow_internal_osc_en, slow_clk_out_en;
    logic always_on_domain_pwr, sensor_pwr, cache_as_ram, brownout_detector_en;
    logic por_det_en, sys_reset_n, bod_lock, ce;
    logic [1:0] kind;
    logic [3:0] addr, pin_idx, sram_pwr;
    logic [7:0] lag;
    logic [15:0] wake_pin_sel, io_in, io_core_out, io_out, io_snap;
    logic [31:0] wdata, rdata, got;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int exp_ret, n;

    pmc_top dut (.clk, .arst_n, .ce, .addr, .wdata, .wr, .rd, .rdata, .irq_any, .rtc_evt,
        .sensor_evt, .reset_pin_n, .por_det, .supply_low, .slow_xtal_fitted, .wake_pin_sel,
        .io_in, .io_core_out, .io_out, .io_latched, .cpu_clk_en, .mem_clk_en, .periph_clk_en,
        .radio_clk_en, .fast_crystal_osc_en, .fast_crystal_dbl_en, .fast_internal_osc_en,
        .slow_crystal_osc_en, .slow_internal_osc_en, .slow_clk_out_en, .always_on_domain_pwr,
        .sensor_pwr, .sram_pwr, .cache_as_ram, .brownout_detector_en, .por_det_en,
        .sys_reset_n, .bod_lock);
    pmc_wake_partner partner (.clk, .go, .kind, .lag, .hold_pin, .pin_idx, .irq_any,
        .rtc_evt, .sensor_evt, .reset_pin_n, .io_in);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // run is about 71k cycles; well short of this ceiling
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        got = rdata;
    endtask

    // returns once the event has been shown, so wake counts start there
    task automatic fire(logic [1:0] k);
        int l;
        l = $urandom_range(0, 15);
        @(posedge clk);
        kind <= k;
        lag <= 8'(l);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (l + 2) @(posedge clk);
    endtask

    task automatic settle(int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wake_chk(string what, int base);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < base + 40) begin
            settle(1);
            n++;
        end
        chk(what, 1, 32'(n >= base - 4 && n <= base + 6));
        $display("test %s done after %0d cycles", what, n);
    endtask

    initial begin
        void'($urandom(27));
        {arst_n, wr, rd, go, hold_pin, supply_low, por_det} = '0;
        ce = 1'b1;
        addr = '0;
        wdata = '0;
        kind = '0;
        lag = '0;
        slow_xtal_fitted = 1'($urandom_range(0, 1));
        pin_idx = 4'($urandom_range(0, 15));
        wake_pin_sel = 16'h0001 << pin_idx;
        io_core_out = 16'($urandom);
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        wake_chk("power-up", 20299);
        chk("por detect", 1, por_det_en);
        chk("fast xtal", 1, fast_crystal_osc_en & fast_crystal_dbl_en);
        chk("slow xtal", slow_xtal_fitted, slow_crystal_osc_en);
        chk("slow rc", !slow_xtal_fitted, slow_internal_osc_en);
        rd_reg(ADDR_RET);
        chk("ret reset", RET_RESET, got);
        rd_reg(4'hf);
        chk("unmapped", 0, got);
        // a write while the enable is low must not land
        ce <= 1'b0;
        wr_reg(ADDR_RET, 32'h0);
        ce <= 1'b1;
        rd_reg(ADDR_RET);
        chk("ce freeze", RET_RESET, got);
        wr_reg(ADDR_CLK, 32'h3);
        wr_reg(ADDR_CTRL, 32'h4);
        settle(1);
        chk("internal osc", 1, fast_internal_osc_en);
        chk("slow out", 1, slow_clk_out_en);
        chk("cache ram", 1, cache_as_ram);
        wr_reg(ADDR_CLK, 32'h0);
        wr_reg(ADDR_CTRL, 32'(CMD_IDLE));
        settle(1);
        chk("idle cpu", 0, cpu_clk_en | mem_clk_en);
        chk("idle periph", 1, periph_clk_en & radio_clk_en);
        chk("idle bod", 1, brownout_detector_en);
        fire(2'h0);
        wake_chk("idle wake", WAKE_IDLE_CYC);
        exp_ret = $urandom_range(0, 14);
        wr_reg(ADDR_RET, 32'(exp_ret));
        wr_reg(ADDR_CTRL, 32'(CMD_STANDBY));
        settle(2);
        chk("stby latch", 1, io_latched);
        chk("stby sram", exp_ret, sram_pwr);
        chk("stby fast", 0, fast_crystal_osc_en | cpu_clk_en | periph_clk_en);
        chk("stby slow", 1, slow_crystal_osc_en | slow_internal_osc_en);
        io_snap = io_out;
        io_core_out <= ~io_core_out;
        n = 0;
        repeat (128) begin
            settle(1);
            n += 32'(brownout_detector_en);
        end
        chk("bod pulses", 2, n);
        chk("stby io held", io_snap, io_out);
        fire(2'h0);
        fire(2'h2);
        settle(40);
        chk("stby no wake", 0, cpu_clk_en);
        fire(2'h1);
        wake_chk("rtc wake", WAKE_STBY_CYC);
        rd_reg(ADDR_RET);
        chk("ret kept", exp_ret, got);
        rd_reg(ADDR_STAT);
        chk("stat active", 32'(PMC_ACTIVE), got);
        wr_reg(ADDR_CTRL, 32'(CMD_STANDBY) | 32'h8);
        settle(4);
        fire(2'h2);
        wake_chk("sensor wake", WAKE_STBY_CYC);
        wr_reg(ADDR_CTRL, 32'(CMD_STANDBY));
        settle(2);
        supply_low <= 1'b1;
        settle(70);
        supply_low <= 1'b0;
        fire(2'h1);
        settle(WAKE_STBY_CYC + 50);
        chk("bod lock", 1, bod_lock);
        chk("locked cpu", 0, cpu_clk_en);
        hold_pin <= 1'b1;
        settle(4);
        chk("hold reset", 0, sys_reset_n);
        hold_pin <= 1'b0;
        wake_chk("pin release", WAKE_SHDN_CYC);
        chk("lock cleared", 0, bod_lock);
        rd_reg(ADDR_RST);
        chk("pin cause", 1, got[1]);
        wr_reg(ADDR_RST, 32'hf);
        rd_reg(ADDR_RST);
        chk("cause cleared", 0, got);
        io_core_out <= 16'($urandom);
        settle(3);
        io_snap = io_core_out;
        wr_reg(ADDR_RET, 32'h5);
        wr_reg(ADDR_CTRL, 32'(CMD_SHUTDOWN));
        settle(3);
        chk("shdn io", io_snap, io_out);
        io_core_out <= ~io_snap;
        settle(3);
        chk("shdn io held", io_snap, io_out);
        chk("shdn pwr", 0, always_on_domain_pwr | sensor_pwr | (|sram_pwr));
        chk("shdn bod", 0, brownout_detector_en);
        chk("shdn por", 1, por_det_en);
        chk("shdn fast", 0, fast_crystal_osc_en | sys_reset_n);
        fire(2'h3);
        wake_chk("wake pin", WAKE_SHDN_CYC);
        rd_reg(ADDR_RST);
        chk("wakepin cause", 1, got[2]);
        rd_reg(ADDR_RET);
        chk("ret lost", RET_RESET, got);
        por_det <= 1'b1;
        settle(1);
        por_det <= 1'b0;
        rd_reg(ADDR_RST);
        chk("por cause", 32'(RST_POR), got);
        close_out();
    end
endmodule
`default_nettype wire
